// file: rtl/sap_defines.svh
// register offsets, field positions, reset values and timing counts of the serial audio link
`ifndef SAP_DEFINES_SVH
`define SAP_DEFINES_SVH

// device register offsets
`define SAP_REG_MASTER_SEL   8'h09
`define SAP_REG_BCLK_DIV     8'h20
`define SAP_REG_FRAME_DIV    8'h21
`define SAP_REG_FORMAT       8'h28
`define SAP_REG_TDM_OFFSET   8'h29

// device field positions
`define SAP_MS_MASTER        0
`define SAP_MS_BCLK_OUT      4
`define SAP_MS_FRAME_OUT     5
`define SAP_FMT_LSB          4
`define SAP_WL_LSB           0

// device reset values: slave, i2s, 24 bit
`define SAP_MS_RESET         8'h00
`define SAP_BCLK_DIV_RESET   8'h07
`define SAP_FRAME_DIV_RESET  8'h3f
`define SAP_FORMAT_RESET     8'h02
`define SAP_TDM_OFF_RESET    8'h00

// lock supervision counts
`define SAP_MCLK_TOL         5
`define SAP_BAD_FRAMES       4
`define SAP_RESYNC_FRAMES    2

// host apb register offsets
`define SAP_H_CTRL           12'h000
`define SAP_H_BCLK_DIV       12'h004
`define SAP_H_FRAME_DIV      12'h008
`define SAP_H_LEFT           12'h00c
`define SAP_H_RIGHT          12'h010
`define SAP_H_STATUS         12'h014

// host control fields
`define SAP_H_OWN            0
`define SAP_H_FMT_LSB        1
`define SAP_H_WL_LSB         3
`define SAP_H_OFF_LSB        8
`define SAP_H_CTRL_RESET     32'h0000_0005

`endif

// file: rtl/sap_pkg.sv
// types shared by both ends of the serial audio link, and the device lock states
package sap_pkg;
    typedef enum logic [1:0] {
        fmt_i2s = 2'b00,
        left_justified_format  = 2'b01,
        right_justified_format = 2'b10,
        fmt_tdm = 2'b11
    } audio_fmt_e;

    typedef enum logic [1:0] {
        wl_16 = 2'b00,
        wl_20 = 2'b01,
        wl_24 = 2'b10,
        wl_32 = 2'b11
    } word_len_e;

    typedef enum logic [1:0] {
        st_acquire = 2'b01,
        st_locked  = 2'b10
    } sync_state_e;

    // word length code to bit count
    function automatic logic [5:0] word_bits(input logic [1:0] code);
        logic [5:0] n;
        n = 6'h20;
        case (code)
            wl_16: n = 6'h10;
            wl_20: n = 6'h14;
            wl_24: n = 6'h18;
            default: n = 6'h20;
        endcase
        return n;
    endfunction
endpackage

// file: rtl/sap_if.sv
// three-wire serial audio link joining host and device; clock wires resolved from enables
interface sap_if;
    logic dev_bclk_o;
    logic dev_bclk_oe_n;
    logic dev_frame_o;
    logic dev_frame_oe_n;
    logic host_bclk_o;
    logic host_bclk_oe_n;
    logic host_frame_o;
    logic host_frame_oe_n;
    logic serial_data_in;
    logic bit_clock;
    logic frame_clock;

    // wire levels: the enabled driver wins, undriven wire reads low
    assign bit_clock   = !dev_bclk_oe_n ? dev_bclk_o : (!host_bclk_oe_n ? host_bclk_o : 1'b0);
    assign frame_clock = !dev_frame_oe_n ? dev_frame_o : (!host_frame_oe_n ? host_frame_o : 1'b0);

    modport device (
        output dev_bclk_o, dev_bclk_oe_n, dev_frame_o, dev_frame_oe_n,
        input  bit_clock, frame_clock, serial_data_in
    );
    modport host (
        output host_bclk_o, host_bclk_oe_n, host_frame_o, host_frame_oe_n, serial_data_in,
        input  bit_clock, frame_clock
    );
endinterface

// file: rtl/sap_edge_sync.sv
// two-flop synchroniser with rise and fall detection per bit
module sap_edge_sync #(
    parameter int W = 3
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         reset_n,
    // asynchronous inputs
    input  wire logic [W-1:0] d,
    // synchronised level and one-cycle edges
    output logic      [W-1:0] level,
    output logic      [W-1:0] rise,
    output logic      [W-1:0] fall
);
    logic [W-1:0] meta;
    logic [W-1:0] stage;
    logic [W-1:0] last;

    generate
        if (W < 1)
        begin : g_bad_w
            $error("sap_edge_sync needs W of at least 1");
        end
    endgenerate

    // first flop is read only by the second
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            meta  <= '0;
            stage <= '0;
            last  <= '0;
        end
        else
        begin
            meta  <= d;
            stage <= meta;
            last  <= stage;
        end
    end

    // edges compare the settled stage with its delayed copy
    assign level = stage;
    assign rise  = stage & ~last;
    assign fall  = ~stage & last;
endmodule // sap_edge_sync

// file: rtl/serial_audio_input_port.sv
// serial audio input port: device end of the three-wire link
//
// Decided for this implementation: register access over a plain write, address and data port, not APB.
`include "sap_defines.svh"

module serial_audio_input_port #(
    parameter int MCLK_TOL   = `SAP_MCLK_TOL,
    parameter int BAD_FRAMES = `SAP_BAD_FRAMES,
    parameter int RESYNC     = `SAP_RESYNC_FRAMES
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // audio link
    sap_if.device            link,
    // register port
    input  wire logic        reg_wr,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    // hardware configuration strap
    input  wire logic        hw_mode,
    // received samples, msb aligned
    output logic      [31:0] left_sample,
    output logic      [31:0] right_sample,
    output logic      [1:0]  sample_valid,
    // lock status
    output logic             outputs_zeroed,
    output logic      [1:0]  sync_error
);
    generate
        if (MCLK_TOL < 1 || MCLK_TOL > 1000 || BAD_FRAMES < 1 || BAD_FRAMES > 14 || RESYNC < 1 || RESYNC > 7)
        begin : g_bad_param
            $error("serial_audio_input_port parameter out of range");
        end
    endgenerate

    logic [7:0] ms_sel;
    logic [7:0] bclk_div;
    logic [7:0] frame_div;
    logic [7:0] fmt_reg;
    logic [7:0] tdm_off;
    // synchronised link wires and strap pin
    logic [3:0] s_lvl;
    logic [3:0] s_rise;
    wire        hw_strap = s_lvl[3];

    // register decode
    wire hit_ms  = (reg_addr == `SAP_REG_MASTER_SEL);
    wire hit_bd  = (reg_addr == `SAP_REG_BCLK_DIV);
    wire hit_fd  = (reg_addr == `SAP_REG_FRAME_DIV);
    wire hit_fmt = (reg_addr == `SAP_REG_FORMAT);
    wire hit_off = (reg_addr == `SAP_REG_TDM_OFFSET);
    wire [7:0] next_rdata = hit_ms ? ms_sel : hit_bd ? {1'b0, bclk_div[6:0]} : hit_fd ? frame_div :
                            hit_fmt ? fmt_reg : hit_off ? tdm_off : 8'h00;

    // register writes and registered read data
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ms_sel    <= `SAP_MS_RESET;
            bclk_div  <= `SAP_BCLK_DIV_RESET;
            frame_div <= `SAP_FRAME_DIV_RESET;
            fmt_reg   <= `SAP_FORMAT_RESET;
            tdm_off   <= `SAP_TDM_OFF_RESET;
            reg_rdata <= 8'h00;
        end
        else
        begin
            if (reg_wr && hit_ms) ms_sel <= reg_wdata;
            if (reg_wr && hit_bd) bclk_div <= reg_wdata;
            if (reg_wr && hit_fd) frame_div <= reg_wdata;
            if (reg_wr && hit_fmt) fmt_reg <= reg_wdata;
            if (reg_wr && hit_off) tdm_off <= reg_wdata;
            reg_rdata <= next_rdata;
        end
    end

    wire [1:0] fmt_raw = fmt_reg[`SAP_FMT_LSB+1:`SAP_FMT_LSB];
    wire [1:0] fmt     = (hw_strap && fmt_raw[1]) ? sap_pkg::fmt_i2s : fmt_raw;
    wire is_i2s = (fmt == sap_pkg::fmt_i2s);
    wire is_rjust = (fmt == sap_pkg::right_justified_format);
    wire is_tdm = (fmt == sap_pkg::fmt_tdm);
    wire [5:0] wl       = sap_pkg::word_bits(fmt_reg[`SAP_WL_LSB+1:`SAP_WL_LSB]);
    wire [8:0] wl9      = {3'b000, wl};
    wire [5:0] wl_shift = 6'h20 - wl;

    wire master_on = ms_sel[`SAP_MS_MASTER] & ms_sel[`SAP_MS_BCLK_OUT] & ms_sel[`SAP_MS_FRAME_OUT];

    logic [6:0] mdiv;
    logic [7:0] mfcnt;
    logic       mbclk;
    logic       mframe;
    wire       m_tick      = (mdiv == bclk_div[6:0]);
    wire       m_fall      = m_tick & mbclk;
    wire [7:0] next_mfcnt  = (mfcnt == frame_div) ? 8'h00 : mfcnt + 8'h01;
    wire [7:0] m_half      = 8'((9'(frame_div) + 9'h001) >> 1);
    wire       next_mframe = is_tdm ? (next_mfcnt == 8'h00) :
                             is_i2s ? (next_mfcnt >= m_half) : (next_mfcnt < m_half);

    // master clock generation, frame moves on bit clock fall
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            mdiv   <= 7'h00;
            mfcnt  <= 8'h00;
            mbclk  <= 1'b0;
            mframe <= 1'b0;
        end
        else if (!master_on)
        begin
            mdiv   <= 7'h00;
            mfcnt  <= 8'h00;
            mbclk  <= 1'b0;
            mframe <= 1'b0;
        end
        else
        begin
            mdiv <= m_tick ? 7'h00 : mdiv + 7'h01;
            if (m_tick) mbclk <= ~mbclk;
            if (m_fall) mfcnt <= next_mfcnt;
            if (m_fall) mframe <= next_mframe;
        end
    end

    // link pin drivers, enable low while driving
    assign link.dev_bclk_o     = mbclk;
    assign link.dev_frame_o    = mframe;
    assign link.dev_bclk_oe_n  = ~master_on;
    assign link.dev_frame_oe_n = ~master_on;

    // the three link wires enter here, strap pin too
    sap_edge_sync #(.W(4)) u_sync (
        .clk     (clk),
        .reset_n (reset_n),
        .d       ({hw_mode, link.serial_data_in, link.bit_clock, link.frame_clock}),
        .level   (s_lvl),
        .rise    (s_rise),
        .fall    ()
    );
    wire fs    = s_lvl[0];
    wire frise = s_rise[0];
    wire brise = s_rise[1];
    wire din   = s_lvl[2];

    logic                 prev_fs;
    logic [8:0]           pos;
    logic [31:0]          sh;
    sap_pkg::sync_state_e state;
    wire locked = (state == sap_pkg::st_locked);

    wire        trans   = is_tdm ? (fs & ~prev_fs) : (fs ^ prev_fs);
    wire [8:0]  pos_now = trans ? 9'h000 : pos + 9'h001;
    wire [8:0]  lead    = is_i2s ? 9'h001 : (is_tdm ? {1'b0, tdm_off} : 9'h000);
    wire [8:0]  k       = pos_now - lead;
    wire        in_win  = (pos_now >= lead);
    wire        done0   = in_win & (k == wl9 - 9'h001);
    wire        done1   = in_win & is_tdm & (k == {wl9[7:0], 1'b0} - 9'h001);
    wire [31:0] new_sh  = {sh[30:0], din};
    wire [31:0] win_word = new_sh << wl_shift;
    wire [31:0] tail_word = sh << wl_shift;
    // right justified frame high is left
    wire        first_ch = is_tdm | (is_i2s ? ~fs : fs);
    // left or slot 1 to first channel
    wire        store_l = is_rjust ? (trans & prev_fs) : (done0 & first_ch);
    wire        store_r = is_rjust ? (trans & ~prev_fs) : (done1 | (done0 & ~first_ch));

    // while locked, act only on bit clock rise; held clear while unlocked
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            prev_fs      <= 1'b0;
            pos          <= 9'h000;
            sh           <= 32'h0000_0000;
            left_sample  <= 32'h0000_0000;
            right_sample <= 32'h0000_0000;
            sample_valid <= 2'b00;
        end
        else if (!locked)
        begin
            prev_fs      <= fs;
            pos          <= 9'h000;
            sh           <= 32'h0000_0000;
            left_sample  <= 32'h0000_0000;
            right_sample <= 32'h0000_0000;
            sample_valid <= 2'b00;
        end
        else
        begin
            sample_valid <= brise ? {store_r, store_l} : 2'b00;
            if (brise) prev_fs <= fs;
            if (brise) pos <= pos_now;
            if (brise) sh <= new_sh;
            if (brise && store_l) left_sample <= is_rjust ? tail_word : win_word;
            if (brise && store_r) right_sample <= is_rjust ? tail_word : win_word;
        end
    end

    logic [15:0] per_cnt;
    logic [15:0] per_last;
    logic        have_last;
    logic [8:0]  bc_cnt;
    logic [8:0]  bc_last;
    logic [3:0]  bad_cnt;
    logic [2:0]  good_cnt;
    wire [15:0] per_diff = (per_cnt > per_last) ? per_cnt - per_last : per_last - per_cnt;
    wire mclk_bad = have_last & (17'(per_diff) > 17'(MCLK_TOL));
    wire late     = have_last & (17'(per_cnt) > 17'(per_last) + 17'(MCLK_TOL));
    // bit clocks per frame must fit format
    wire rate_ok  = is_tdm ? (bc_cnt == bc_last) :
                    ((bc_cnt == 9'd32) || (bc_cnt == 9'd48) || (bc_cnt == 9'd64));
    wire frame_bad = mclk_bad | ~rate_ok;
    wire lose_rate = frise & ~rate_ok & (bad_cnt >= 4'(BAD_FRAMES));
    wire lose_mclk = (frise & mclk_bad) | late;

    // period and bit counters between frame rises
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            per_cnt   <= 16'h0000;
            per_last  <= 16'h0000;
            have_last <= 1'b0;
            bc_cnt    <= 9'h000;
            bc_last   <= 9'h000;
        end
        else
        begin
            per_cnt   <= frise ? 16'h0000 : ((per_cnt == 16'hffff) ? per_cnt : per_cnt + 16'h0001);
            bc_cnt    <= frise ? 9'h000 : (brise ? bc_cnt + 9'h001 : bc_cnt);
            if (frise) per_last <= per_cnt;
            if (frise) bc_last <= bc_cnt;
            if (frise) have_last <= 1'b1;
        end
    end

    // lock state machine: loss reinitialises at once, relock after good frames
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state      <= sap_pkg::st_acquire;
            bad_cnt    <= 4'h0;
            good_cnt   <= 3'h0;
            sync_error <= 2'b00;
        end
        else
        begin
            case (state)
                sap_pkg::st_acquire:
                begin
                    bad_cnt <= 4'h0;
                    if (frise) good_cnt <= frame_bad ? 3'h0 : good_cnt + 3'h1;
                    if (frise && !frame_bad && (good_cnt + 3'h1 >= 3'(RESYNC)))
                    begin
                        state      <= sap_pkg::st_locked;
                        sync_error <= 2'b00;
                    end
                end
                sap_pkg::st_locked:
                begin
                    good_cnt <= 3'h0;
                    if (frise) bad_cnt <= rate_ok ? 4'h0 : bad_cnt + 4'h1;
                    if (lose_mclk || lose_rate)
                    begin
                        state      <= sap_pkg::st_acquire;
                        sync_error <= {lose_rate, lose_mclk};
                    end
                end
                default:
                begin
                    state <= sap_pkg::st_acquire;
                end
            endcase
        end
    end

    // bipolar zero while not locked
    assign outputs_zeroed = ~locked;
endmodule // serial_audio_input_port

// file: rtl/serial_audio_source.sv
// serial audio source: host end of the link, controlled over apb
`include "sap_defines.svh"

module serial_audio_source (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // audio link
    sap_if.host              link
);
    logic [31:0] ctrl;
    logic [7:0]  bclk_div;
    logic [7:0]  frame_div;
    logic [31:0] left_word;
    logic [31:0] right_word;
    logic        frame_flag;

    // apb decode
    wire hit_ctrl = (paddr == `SAP_H_CTRL);
    wire hit_bd   = (paddr == `SAP_H_BCLK_DIV);
    wire hit_fd   = (paddr == `SAP_H_FRAME_DIV);
    wire hit_l    = (paddr == `SAP_H_LEFT);
    wire hit_r    = (paddr == `SAP_H_RIGHT);
    wire hit_st   = (paddr == `SAP_H_STATUS);
    wire mapped   = hit_ctrl | hit_bd | hit_fd | hit_l | hit_r | hit_st;
    wire wr       = psel & penable & pwrite & mapped;
    wire [31:0] next_prdata = hit_ctrl ? ctrl : hit_bd ? {25'h0, bclk_div[6:0]} : hit_fd ? {24'h0, frame_div} :
                              hit_l ? left_word : hit_r ? right_word : hit_st ? {31'h0, frame_flag} : 32'h0;
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    wire own    = ctrl[`SAP_H_OWN];
    wire [1:0] fmt = ctrl[`SAP_H_FMT_LSB+1:`SAP_H_FMT_LSB];
    wire is_i2s = (fmt == sap_pkg::fmt_i2s);
    wire is_rjust = (fmt == sap_pkg::right_justified_format);
    wire is_tdm = (fmt == sap_pkg::fmt_tdm);
    wire [8:0] wl9 = {3'b000, sap_pkg::word_bits(ctrl[`SAP_H_WL_LSB+1:`SAP_H_WL_LSB])};

    // tdm sync one bit
    // own clock generator, frame moves on bit clock fall; a stop waits for the low phase
    logic [6:0] gdiv;
    logic [7:0] gfcnt;
    logic       gbclk;
    logic       gframe;
    wire       g_tick      = (gdiv == bclk_div[6:0]);
    wire       g_fall      = g_tick & gbclk;
    wire [7:0] next_gfcnt  = (gfcnt == frame_div) ? 8'h00 : gfcnt + 8'h01;
    wire [7:0] g_half      = 8'((9'(frame_div) + 9'h001) >> 1);
    wire       next_gframe = is_tdm ? (next_gfcnt == 8'h00) :
                             is_i2s ? (next_gfcnt >= g_half) : (next_gfcnt < g_half);

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            gdiv   <= 7'h00;
            gfcnt  <= 8'h00;
            gbclk  <= 1'b0;
            gframe <= 1'b0;
        end
        else if (!own && !gbclk)
        begin
            gdiv   <= 7'h00;
            gfcnt  <= 8'h00;
            gbclk  <= 1'b0;
            gframe <= 1'b0;
        end
        else
        begin
            gdiv <= g_tick ? 7'h00 : gdiv + 7'h01;
            if (g_tick) gbclk <= ~gbclk;
            if (g_fall) gfcnt <= next_gfcnt;
            if (g_fall) gframe <= next_gframe;
        end
    end

    assign link.host_bclk_o     = gbclk;
    assign link.host_frame_o    = gframe;
    // keep driving until a running high phase has ended, so no runt pulse
    assign link.host_bclk_oe_n  = ~(own | gbclk);
    assign link.host_frame_oe_n = ~(own | gbclk);

    // device-made clocks are synchronised before use
    logic [1:0] s_lvl;
    logic [1:0] s_fall;
    sap_edge_sync #(.W(2)) u_sync (
        .clk     (clk),
        .reset_n (reset_n),
        .d       ({link.bit_clock, link.frame_clock}),
        .level   (s_lvl),
        .rise    (),
        .fall    (s_fall)
    );

    logic        prev_fr;
    logic [8:0]  p;
    logic [31:0] tx_left;
    logic [31:0] tx_right;
    logic        sdata;
    wire        fall_ev = own ? g_fall : s_fall[1];
    wire        fr_now  = own ? next_gframe : s_lvl[0];
    wire        trans   = is_tdm ? (fr_now & ~prev_fr) : (fr_now ^ prev_fr);
    wire [8:0]  p_now   = trans ? 9'h000 : p + 9'h001;
    wire        left_h  = is_tdm | (is_i2s ? ~fr_now : fr_now);
    wire        start_l = trans & left_h;
    wire [31:0] lw      = start_l ? left_word : tx_left;
    wire [31:0] rw      = start_l ? right_word : tx_right;
    wire [8:0]  half    = {1'b0, g_half};
    // msb placement per format, data driven on fall for rise sampling
    wire [8:0]  lead    = is_i2s ? 9'h001 : is_tdm ? {1'b0, ctrl[`SAP_H_OFF_LSB+7:`SAP_H_OFF_LSB]} :
                          is_rjust ? half - wl9 : 9'h000;
    wire [8:0]  k       = p_now - lead;
    wire        use_r   = is_tdm ? (k >= wl9) : ~left_h;
    wire [8:0]  kk      = (is_tdm && k >= wl9) ? k - wl9 : k;
    wire [31:0] sel_w   = use_r ? rw : lw;
    wire        next_bit = (p_now >= lead) && (kk < wl9) && sel_w[5'(9'd31 - kk)];

    // apb registers, prdata set up in the setup cycle; sticky flag set wins over clear
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrl       <= `SAP_H_CTRL_RESET;
            bclk_div   <= `SAP_BCLK_DIV_RESET;
            frame_div  <= `SAP_FRAME_DIV_RESET;
            left_word  <= 32'h0000_0000;
            right_word <= 32'h0000_0000;
            frame_flag <= 1'b0;
            prdata     <= 32'h0000_0000;
        end
        else
        begin
            if (psel && !penable) prdata <= next_prdata;
            if (wr && hit_ctrl) ctrl <= pwdata;
            if (wr && hit_bd) bclk_div <= pwdata[7:0];
            if (wr && hit_fd) frame_div <= pwdata[7:0];
            if (wr && hit_l) left_word <= pwdata;
            if (wr && hit_r) right_word <= pwdata;
            frame_flag <= (fall_ev & start_l) | (frame_flag & ~(wr & hit_st & pwdata[0]));
        end
    end

    // transmitter: one bit per bit clock fall
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            prev_fr  <= 1'b0;
            p        <= 9'h000;
            tx_left  <= 32'h0000_0000;
            tx_right <= 32'h0000_0000;
            sdata    <= 1'b0;
        end
        else if (fall_ev)
        begin
            prev_fr  <= fr_now;
            p        <= p_now;
            tx_left  <= lw;
            tx_right <= rw;
            sdata    <= next_bit;
        end
    end

    assign link.serial_data_in = sdata;
endmodule // serial_audio_source

// file: verification/sap_checker.sv
// wire-level assertions on the serial audio link
module sap_checker (
    // clock and reset
    input logic clk,
    input logic reset_n,
    // link wires
    input logic dev_bclk_o,
    input logic dev_bclk_oe_n,
    input logic dev_frame_oe_n,
    input logic host_bclk_oe_n,
    input logic host_frame_oe_n,
    input logic bit_clock,
    input logic frame_clock,
    input logic serial_data_in
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // driver ownership and wire levels
    bclk_single_a: assert property (dev_bclk_oe_n || host_bclk_oe_n) else $error("clock contention");
    dev_pair_a: assert property (dev_bclk_oe_n == dev_frame_oe_n) else $error("device clocks split");
    host_pair_a: assert property (host_bclk_oe_n == host_frame_oe_n) else $error("host clocks split");
    idle_low_a: assert property (dev_bclk_oe_n && host_bclk_oe_n |-> !bit_clock) else $error("idle clock high");
    dev_wire_a: assert property (!dev_bclk_oe_n |-> bit_clock == dev_bclk_o) else $error("device clock lost");
    // data and frame timing against the bit clock, and bit clock high time
    data_hold_a: assert property (bit_clock && $past(bit_clock) |-> $stable(serial_data_in)) else $error("data moved");
    frame_fall_a: assert property ($changed(frame_clock) |-> !bit_clock) else $error("frame off fall");
    bclk_half_a: assert property ($rose(bit_clock) |=> bit_clock [*3]) else $error("clock high short");
    // main scenarios reached
    dev_master_c: cover property ($fell(dev_bclk_oe_n));
    host_master_c: cover property ($fell(host_bclk_oe_n));
    frame_start_c: cover property ($rose(frame_clock));
endmodule // sap_checker

// file: verification/tb_top.sv
// bench: host source feeds the device input port over the link
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, left_sample, right_sample;
    logic [1:0]  sample_valid, sync_error;
    logic        pready, outputs_zeroed, hw_mode = 1'b0;
    int          n_mismatch = 0, checks_done = 0;
    sap_if link ();
    // both ends and the checker on the link
    serial_audio_input_port i_serial_audio_input_port (.clk, .reset_n, .link(link.device), .reg_wr, .reg_addr,
        .reg_wdata, .reg_rdata, .hw_mode, .left_sample, .right_sample, .sample_valid, .outputs_zeroed, .sync_error);
    serial_audio_source i_serial_audio_source (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr(), .link(link.host));
    sap_checker i_sap_checker (.clk, .reset_n, .dev_bclk_o(link.dev_bclk_o), .dev_bclk_oe_n(link.dev_bclk_oe_n),
        .dev_frame_oe_n(link.dev_frame_oe_n), .host_bclk_oe_n(link.host_bclk_oe_n),
        .host_frame_oe_n(link.host_frame_oe_n), .bit_clock(link.bit_clock), .frame_clock(link.frame_clock),
        .serial_data_in(link.serial_data_in));
    // 100 MHz clock
    initial forever #5 clk = ~clk;
    // compare one value
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // apb transfer, held until pready
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // device register write and read back
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_addr <= a;
        @(posedge clk);
        @(negedge clk);
        chk("device reg", {24'h0, exp}, {24'h0, reg_rdata});
    endtask
    // wait for a second stored word on one channel
    task automatic wait_valid(input int b);
        repeat (2)
        begin
            @(negedge clk);
            while (sample_valid[b] !== 1'b1)
                @(negedge clk);
        end
    endtask
    // defaults after reset
    task automatic t_reset;
        rreg(8'h28, 8'h02);
        rreg(8'h09, 8'h00);
        rreg(8'h55, 8'h00);
        apb(1'b0, 12'h000, 32'h0);
        chk("host ctrl", 32'h5, prdata);
        chk("zeroed", 32'h1, {31'h0, outputs_zeroed});
        $display("test reset done");
    endtask
    // one format with its own word length, host owns clocks
    // code 4: strap high, right justified code must fall back to i2s
    task automatic t_fmt(input logic [2:0] f);
        logic [31:0] m;
        m = 32'hffff_ffff << ((f[1:0] == 2'b11) ? 0 : 16 - 4 * f[1:0]);
        apb(1'b1, 12'h00c, 32'h8123_4567);
        hw_mode <= f[2];
        apb(1'b1, 12'h010, 32'h6edc_ba98);
        apb(1'b1, 12'h000, {27'h0, f[1:0], f[1:0], 1'b1});
        wreg(8'h28, {2'b00, f[2] ? 2'b10 : f[1:0], 2'b00, f[1:0]});
        wait_valid(0);
        chk("left", 32'h8123_4567 & m, left_sample);
        wait_valid(1);
        chk("right", 32'h6edc_ba98 & m, right_sample);
        $display("test format %0d done", f);
    endtask
    // clocks stop: frame overdue past tolerance
    task automatic t_loss;
        apb(1'b1, 12'h000, 32'h0);
        repeat (600) @(negedge clk);
        chk("zeroed", 32'h1, {31'h0, outputs_zeroed});
        chk("sync error", 32'h1, {30'h0, sync_error});
        chk("left zero", 32'h0, left_sample);
        // forty bit clocks per frame must never lock
        apb(1'b1, 12'h008, 32'h27);
        apb(1'b1, 12'h000, 32'h3);
        repeat (3000) @(negedge clk);
        chk("bad rate zeroed", 32'h1, {31'h0, outputs_zeroed});
        apb(1'b1, 12'h000, 32'h0);
        $display("test loss done");
    endtask
    // device makes clocks, host follows in left justified 16 bit
    task automatic t_master;
        wreg(8'h20, 8'h83);
        rreg(8'h20, 8'h03);
        wreg(8'h21, 8'h3f);
        wreg(8'h28, 8'h10);
        wreg(8'h09, 8'h31);
        apb(1'b1, 12'h000, 32'h2);
        wait_valid(0);
        chk("master left", 32'h8123_0000, left_sample);
        $display("test master done");
    endtask
    // verdict and end of run
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // reset, then the scenarios
    initial
    begin
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        t_reset;
        apb(1'b1, 12'h004, 32'h3);
        apb(1'b1, 12'h008, 32'h3f);
        for (int f = 0; f < 5; f++)
            t_fmt(f[2:0]);
        t_loss;
        t_master;
        end_of_test;
    end
    // watchdog well beyond the expected run
    initial
    begin
        repeat (40000) @(posedge clk);
        n_mismatch++;
        end_of_test;
    end
endmodule // tb_top
